// File: hdl/sac_pkg.sv
// Package of constants and types for the converter control block
package sac_pkg;
	localparam int          RES_W          = 10;
	localparam int          CH_W           = 5;
	localparam int          TRIG_W         = 3;
	localparam int          PRE_W          = 7;
	localparam logic [4:0]  CYC_NORMAL     = 5'd13;
	localparam logic [4:0]  CYC_FIRST      = 5'd25;
	localparam logic [4:0]  CYC_SH_FIRST   = 5'h0d;
	localparam logic [4:0]  CYC_SH_NORMAL  = 5'h01;
	localparam logic [2:0]  TRIG_SELF      = 3'h0;
	localparam logic [4:0]  CH_SE_LAST     = 5'h07;
	localparam logic [4:0]  CH_BANDGAP     = 5'h1e;
	localparam logic [4:0]  CH_GROUND      = 5'h1f;
	localparam logic [4:0]  CH_G10_FIRST   = 5'h08;
	localparam logic [4:0]  CH_G200_FIRST  = 5'h0c;
	localparam logic [4:0]  CH_G1_FIRST    = 5'h10;
	localparam logic [1:0]  REF_EXT        = 2'h0;
	localparam logic [1:0]  REF_SUPPLY     = 2'h1;
	localparam logic [1:0]  REF_INT256     = 2'h3;
	localparam logic [1:0]  GAIN_1X        = 2'h0;
	localparam logic [1:0]  GAIN_10X       = 2'h1;
	localparam logic [1:0]  GAIN_200X      = 2'h2;
	localparam logic [1:0]  GAIN_BYPASS    = 2'h3;
	typedef enum logic [1:0] {ST_IDLE, ST_CONV} sac_state_e;
endpackage : sac_pkg

// File: hdl/sac_tick_if.sv
// Interface carrying the prescaler tick between the two modules
`timescale 1ns/1ps
interface sac_tick_if;
	logic enable;
	logic restart;
	logic tick;
	modport ctrl (output enable, output restart, input tick);
	modport pre  (input enable, input restart, output tick);
endinterface : sac_tick_if

// File: hdl/sac_prescaler.sv
// Converter clock prescaler producing a one-cycle tick enable
`timescale 1ns/1ps
module sac_prescaler
	import sac_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [2:0]       divSel,
	sac_tick_if.pre               tickIf
);
	logic [PRE_W-1:0] cnt_reg;
	logic [PRE_W-1:0] limit;

	// Divide by 2 to the power of divSel (at least 2)
	always_comb begin
		limit = (divSel == 3'h0) ? 7'h01 : 7'((8'h01 << divSel) - 8'h01);
	end

	// Counter held in reset while disabled or restarted
	always_ff @(posedge clk) begin
		if (srst || !tickIf.enable || tickIf.restart) begin
			cnt_reg <= '0;
		end else if (cnt_reg >= limit) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
		end
	end

	assign tickIf.tick = tickIf.enable && !tickIf.restart && (cnt_reg >= limit);
endmodule : sac_prescaler

// File: hdl/sac_control.sv
// Conversion control of the successive-approximation converter
`timescale 1ns/1ps
module sac_control
	import sac_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             converterEnable,
	input  wire logic             startConversionWrite,
	input  wire logic             autoTriggerEnable,
	input  wire logic [TRIG_W-1:0] triggerSelectField,
	input  wire logic [7:0]       triggerSources,
	input  wire logic             leftAdjustBit,
	input  wire logic [CH_W-1:0]  channelSelectField,
	input  wire logic [1:0]       referenceSelectBits,
	input  wire logic [2:0]       prescaleSelect,
	input  wire logic             flagClearWrite,
	input  wire logic             vectorTaken,
	input  wire logic             lowByteRead,
	input  wire logic             highByteRead,
	input  wire logic             compareIn,
	output logic                  startConversionBit,
	output logic                  conversionCompleteFlag,
	output logic [7:0]            resultHighByte,
	output logic [7:0]            resultLowByte,
	output logic                  resultBlocked,
	output logic [CH_W-1:0]       activeChannel,
	output logic [1:0]            activeReference,
	output logic [1:0]            gainSelect,
	output logic                  gainStageOn,
	output logic                  sampleHold,
	output logic                  dacValid,
	output logic [RES_W-1:0]      dacCode
);
	// ********************************************************
	// Prescaler and synchronisers
	// ********************************************************
	sac_tick_if tickIf ();

	sac_prescaler sac_prescaler_inst (
		.clk    (clk),
		.srst   (srst),
		.divSel (prescaleSelect),
		.tickIf (tickIf)
	);

	logic [7:0] trigMeta_reg;
	logic [7:0] trigSync_reg;
	logic       cmpMeta_reg;
	logic       cmpSync_reg;

	// Two-stage synchronisers on asynchronous sources
	always_ff @(posedge clk) begin
		if (srst) begin
			trigMeta_reg <= 8'h00;
			trigSync_reg <= 8'h00;
			cmpMeta_reg  <= 1'b0;
			cmpSync_reg  <= 1'b0;
		end else begin
			trigMeta_reg <= triggerSources;
			trigSync_reg <= trigMeta_reg;
			cmpMeta_reg  <= compareIn;
			cmpSync_reg  <= cmpMeta_reg;
		end
	end

	// ********************************************************
	// Start logic
	// ********************************************************
	sac_state_e  state_reg;
	logic        firstConv_reg;
	logic [4:0]  cycCnt_reg;
	logic [RES_W-1:0] sar_reg;
	logic [3:0]  bitIdx_reg;
	logic        trigLevel;
	logic        trigPrev_reg;
	logic        trigEdge;
	logic        pendStart_reg;
	logic        done;
	logic        freeRun;
	logic        autoStart;
	logic [4:0]  convLen;

	assign freeRun   = autoTriggerEnable && (triggerSelectField == TRIG_SELF);
	assign trigLevel = trigSync_reg[triggerSelectField];
	assign trigEdge  = trigLevel && !trigPrev_reg;
	// Edge only counts while idle; edges during conversion are lost
	assign autoStart = converterEnable && autoTriggerEnable && !freeRun
		&& trigEdge && (state_reg == ST_IDLE);
	assign convLen   = firstConv_reg ? CYC_FIRST : CYC_NORMAL;
	assign done      = (state_reg == ST_CONV) && tickIf.tick
		&& (cycCnt_reg == convLen - 5'd1);

	assign tickIf.enable  = converterEnable;
	assign tickIf.restart = autoStart;

	// Previous trigger level for edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			trigPrev_reg <= 1'b0;
		end else begin
			trigPrev_reg <= trigLevel;
		end
	end

	// Software start request waits for next converter clock edge
	always_ff @(posedge clk) begin
		if (srst || !converterEnable) begin
			pendStart_reg <= 1'b0;
		end else if (startConversionWrite && state_reg == ST_IDLE) begin
			pendStart_reg <= 1'b1;
		end else if (state_reg == ST_CONV) begin
			pendStart_reg <= 1'b0;
		end
	end

	// Conversion sequencer
	always_ff @(posedge clk) begin
		if (srst || !converterEnable) begin
			state_reg  <= ST_IDLE;
			cycCnt_reg <= 5'd0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (autoStart || (pendStart_reg && tickIf.tick)) begin
						state_reg  <= ST_CONV;
						cycCnt_reg <= 5'd0;
					end
				end
				ST_CONV: begin
					if (done) begin
						// Free running restarts at once, flag state ignored
						state_reg  <= freeRun ? ST_CONV : ST_IDLE;
						cycCnt_reg <= 5'd0;
					end else if (tickIf.tick) begin
						cycCnt_reg <= cycCnt_reg + 5'd1;
					end
				end
			endcase
		end
	end

	// First conversion after enabling takes the long sequence
	always_ff @(posedge clk) begin
		if (srst || !converterEnable) begin
			firstConv_reg <= 1'b1;
		end else if (done) begin
			firstConv_reg <= 1'b0;
		end
	end

	// Start bit reads one whenever a conversion runs or waits
	assign startConversionBit = (state_reg == ST_CONV) || pendStart_reg;

	// ********************************************************
	// Channel and reference selection
	// ********************************************************
	logic sampleCyc;
	logic selOpen;

	assign sampleCyc = (state_reg == ST_CONV)
		&& (cycCnt_reg == (firstConv_reg ? CYC_SH_FIRST : CYC_SH_NORMAL));
	// Selection follows software until a conversion starts, and again
	// in the last converter cycle
	assign selOpen = (state_reg == ST_IDLE)
		|| (cycCnt_reg == convLen - 5'd1);

	// Active selection latched only while enabled
	always_ff @(posedge clk) begin
		if (srst) begin
			activeChannel   <= CH_GROUND;
			activeReference <= REF_EXT;
		end else if (converterEnable && selOpen && !autoStart) begin
			activeChannel   <= channelSelectField;
			activeReference <= referenceSelectBits;
		end
	end

	// Gain path: bypass for single-ended, ground and bandgap
	always_comb begin
		if (activeChannel >= CH_BANDGAP) begin
			gainSelect = GAIN_BYPASS;
		end else if (activeChannel >= CH_G1_FIRST) begin
			gainSelect = GAIN_1X;
		end else if (activeChannel >= CH_G200_FIRST) begin
			gainSelect = GAIN_200X;
		end else if (activeChannel >= CH_G10_FIRST) begin
			gainSelect = GAIN_10X;
		end else begin
			gainSelect = GAIN_BYPASS;
		end
	end
	assign gainStageOn = converterEnable && (gainSelect != GAIN_BYPASS);
	assign sampleHold  = sampleCyc;

	// ********************************************************
	// Successive approximation
	// ********************************************************
	// Trial code sent to the capacitor array
	always_ff @(posedge clk) begin
		if (srst || state_reg == ST_IDLE) begin
			sar_reg    <= 10'h000;
			bitIdx_reg <= 4'd9;
			dacValid   <= 1'b0;
		end else if (tickIf.tick && sampleCyc) begin
			sar_reg    <= 10'h200;
			bitIdx_reg <= 4'd9;
			dacValid   <= 1'b1;
		end else if (tickIf.tick && dacValid && !done) begin
			// Keep the bit when input is above the trial level
			if (!cmpSync_reg) begin
				sar_reg[bitIdx_reg] <= 1'b0;
			end
			if (bitIdx_reg != 4'd0) begin
				sar_reg[bitIdx_reg - 4'd1] <= 1'b1;
				bitIdx_reg <= bitIdx_reg - 4'd1;
			end else begin
				dacValid <= 1'b0;
			end
		end
	end
	// Code zero is ground, all ones is reference minus one step
	assign dacCode = sar_reg;

	// ********************************************************
	// Result bytes and completion flag
	// ********************************************************
	logic [RES_W-1:0] result_reg;

	// Low byte read locks, high byte read unlocks
	always_ff @(posedge clk) begin
		if (srst) begin
			resultBlocked <= 1'b0;
		end else if (highByteRead) begin
			resultBlocked <= 1'b0;
		end else if (lowByteRead) begin
			resultBlocked <= 1'b1;
		end
	end

	// Completed value stored unless locked
	always_ff @(posedge clk) begin
		if (srst) begin
			result_reg <= 10'h000;
		end else if (done && !resultBlocked) begin
			result_reg <= sar_reg;
		end
	end

	// Justification of the two result bytes
	always_ff @(posedge clk) begin
		if (srst) begin
			resultHighByte <= 8'h00;
			resultLowByte  <= 8'h00;
		end else if (leftAdjustBit) begin
			resultHighByte <= result_reg[9:2];
			resultLowByte  <= {result_reg[1:0], 6'h00};
		end else begin
			resultHighByte <= {6'h00, result_reg[9:8]};
			resultLowByte  <= result_reg[7:0];
		end
	end

	// Flag sets on every completion; set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			conversionCompleteFlag <= 1'b0;
		end else if (done) begin
			conversionCompleteFlag <= 1'b1;
		end else if (flagClearWrite || vectorTaken) begin
			conversionCompleteFlag <= 1'b0;
		end
	end
endmodule : sac_control

// File: testbench/sac_control_assertions.sv
// Port checker of the converter control block
`timescale 1ns/1ps
module sac_control_assertions
	import sac_pkg::*;
(
	input wire logic            clk,
	input wire logic            srst,
	input wire logic            converterEnable,
	input wire logic            startConversionWrite,
	input wire logic            flagClearWrite,
	input wire logic            vectorTaken,
	input wire logic            lowByteRead,
	input wire logic            highByteRead,
	input wire logic            startConversionBit,
	input wire logic            conversionCompleteFlag,
	input wire logic            resultBlocked,
	input wire logic [7:0]      resultHighByte,
	input wire logic [7:0]      resultLowByte,
	input wire logic [CH_W-1:0] activeChannel,
	input wire logic [1:0]      activeReference,
	input wire logic [1:0]      gainSelect,
	input wire logic            sampleHold,
	input wire logic            dacValid,
	input wire logic [RES_W-1:0] dacCode
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// Flag set and clear
	property p_flagHold;
		conversionCompleteFlag && !flagClearWrite && !vectorTaken
			|=> conversionCompleteFlag;
	endproperty
	a_flagHold: assert property (p_flagHold) else $error("flag lost");
	property p_flagClr;
		(flagClearWrite || vectorTaken) && !startConversionBit
			|=> !conversionCompleteFlag;
	endproperty
	a_flagClr: assert property (p_flagClr) else $error("flag kept");
	// Start bit life
	property p_startSets;
		startConversionWrite && converterEnable && !startConversionBit
			|=> startConversionBit;
	endproperty
	a_startSets: assert property (p_startSets) else $error("no start");
	property p_fallFlag;
		$fell(startConversionBit) && converterEnable
			|-> conversionCompleteFlag;
	endproperty
	a_fallFlag: assert property (p_fallFlag) else $error("no flag");
	// Result lock
	property p_lockSet;
		lowByteRead && !highByteRead |=> resultBlocked;
	endproperty
	a_lockSet: assert property (p_lockSet) else $error("no lock");
	property p_unlock;
		highByteRead |=> !resultBlocked;
	endproperty
	a_unlock: assert property (p_unlock) else $error("still locked");
	property p_frozen;
		resultBlocked && $past(resultBlocked, 2) && !highByteRead
			|=> $stable(resultHighByte) && $stable(resultLowByte);
	endproperty
	a_frozen: assert property (p_frozen) else $error("bytes moved");
	// Selection and gain
	property p_selHold;
		!converterEnable && !$past(converterEnable)
			|=> $stable(activeChannel) && $stable(activeReference);
	endproperty
	a_selHold: assert property (p_selHold) else $error("sel moved");
	property p_bypass;
		activeChannel <= CH_SE_LAST |-> gainSelect == GAIN_BYPASS;
	endproperty
	a_bypass: assert property (p_bypass) else $error("gain used");
	// First trial is midscale, right after the sample cycle
	property p_trialStart;
		$rose(dacValid) |-> dacCode == 10'h200 && $past(sampleHold);
	endproperty
	a_trialStart: assert property (p_trialStart) else $error("bad trial");
	c_done: cover property ($rose(conversionCompleteFlag));
	c_lock: cover property ($rose(resultBlocked));
	c_start: cover property (startConversionWrite && !startConversionBit);
endmodule : sac_control_assertions
bind sac_control sac_control_assertions sac_control_assertions_inst (.*);

// File: testbench/sac_mux_model.sv
// Behavioural analog input and comparator facing the converter
`timescale 1ns/1ps
module sac_mux_model
	import sac_pkg::*;
(
	input wire logic [CH_W-1:0]  activeChannel,
	input wire logic [RES_W-1:0] inputLevel,
	input wire logic [RES_W-1:0] dacCode,
	output logic                 compareIn
);
	logic [RES_W-1:0] selLevel;
	// Ground reads as code zero, others as the applied level
	assign selLevel = (activeChannel == CH_GROUND) ? '0 : inputLevel;
	// Input at or above the trial code keeps the bit
	assign compareIn = (selLevel >= dacCode);
endmodule : sac_mux_model

// File: testbench/test_sar_adc_conversion_control.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module test_sar_adc_conversion_control
	import sac_pkg::*;
;
	localparam int     GO = 0, CLR = 1, VEC = 2, RLO = 3, RHI = 4;
	logic              clk, srst, converterEnable, startConversionWrite;
	logic              autoTriggerEnable, leftAdjustBit, flagClearWrite;
	logic              vectorTaken, lowByteRead, highByteRead, compareIn;
	logic              startConversionBit, conversionCompleteFlag;
	logic              resultBlocked, gainStageOn, sampleHold, dacValid;
	logic [TRIG_W-1:0] triggerSelectField;
	logic [7:0]        triggerSources, resultHighByte, resultLowByte;
	logic [CH_W-1:0]   channelSelectField, activeChannel;
	logic [1:0]        referenceSelectBits, activeReference, gainSelect;
	logic [2:0]        prescaleSelect;
	logic [RES_W-1:0]  dacCode, inputLevel;
	int                n_mismatch = 0, checks = 0, cyc = 0, n;
	logic [4:0] chTab [5] = '{5'h00, 5'h08, 5'h0c, 5'h10, 5'h1e};
	logic [1:0] gTab [5] = '{GAIN_BYPASS, GAIN_10X, GAIN_200X, GAIN_1X,
		GAIN_BYPASS};
	logic [1:0] rTab [5] = '{REF_EXT, REF_SUPPLY, REF_INT256, REF_EXT,
		REF_SUPPLY};
	sac_control sac_control_inst (.*);
	sac_mux_model sac_mux_model_inst (.*);
	// ****************
	// Tasks
	// ****************
	task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task pulse(input int w);
		case (w)
			GO: startConversionWrite <= 1'b1;
			CLR: flagClearWrite <= 1'b1;
			VEC: vectorTaken <= 1'b1;
			RLO: lowByteRead <= 1'b1;
			default: highByteRead <= 1'b1;
		endcase
		@(posedge clk);
		{startConversionWrite, flagClearWrite, vectorTaken} <= '0;
		{lowByteRead, highByteRead} <= '0;
		@(posedge clk);
	endtask : pulse
	task waitDone;
		n = 0;
		while (conversionCompleteFlag !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			n_mismatch++;
			$display("Error done expected 1 seen 0");
			stop_test;
		end
	endtask : waitDone
	task stop_test;
		if (n_mismatch == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	// Clock and hang limit
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			$display("Error timeout expected 0 seen 1");
			stop_test;
		end
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{converterEnable, startConversionWrite, autoTriggerEnable} = '0;
		{leftAdjustBit, flagClearWrite, vectorTaken, lowByteRead} = '0;
		{highByteRead, triggerSelectField, triggerSources} = '0;
		prescaleSelect = 3'h2;
		channelSelectField = 5'h03;
		referenceSelectBits = 2'h1;
		inputLevel = 10'h2a5;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("chan", 10'h01f, activeChannel);
		chk("ref", 10'h0, activeReference);
		converterEnable <= 1'b1;
		repeat (3) @(posedge clk);
		chk("chan", 10'h003, activeChannel);
		pulse(GO);
		chk("busy", 10'h1, startConversionBit);
		waitDone;
		chk("first", 10'h1, n >= 96 && n <= 110);
		chk("start", 10'h0, startConversionBit);
		repeat (2) @(posedge clk);
		chk("high", 10'h002, resultHighByte);
		chk("low", 10'h0a5, resultLowByte);
		pulse(CLR);
		chk("flag", 10'h0, conversionCompleteFlag);
		leftAdjustBit <= 1'b1;
		inputLevel <= 10'h3ff;
		pulse(GO);
		waitDone;
		chk("normal", 10'h1, n >= 46 && n <= 60);
		repeat (2) @(posedge clk);
		chk("high", 10'h0ff, resultHighByte);
		chk("low", 10'h0c0, resultLowByte);
		pulse(VEC);
		chk("flag", 10'h0, conversionCompleteFlag);
		pulse(RLO);
		inputLevel <= 10'h155;
		pulse(GO);
		waitDone;
		chk("lockFlag", 10'h1, conversionCompleteFlag);
		repeat (2) @(posedge clk);
		chk("high", 10'h0ff, resultHighByte);
		chk("low", 10'h0c0, resultLowByte);
		pulse(RHI);
		pulse(CLR);
		pulse(GO);
		waitDone;
		repeat (2) @(posedge clk);
		chk("high", 10'h055, resultHighByte);
		chk("low", 10'h040, resultLowByte);
		pulse(CLR);
		leftAdjustBit <= 1'b0;
		channelSelectField <= CH_GROUND;
		pulse(GO);
		waitDone;
		repeat (2) @(posedge clk);
		chk("ground", 10'h0, {resultHighByte[1:0], resultLowByte});
		pulse(CLR);
		for (int i = 0; i < 5; i++) begin
			channelSelectField <= chTab[i];
			referenceSelectBits <= rTab[i];
			repeat (3) @(posedge clk);
			chk("gain", gTab[i], gainSelect);
			chk("gainOn", gTab[i] != GAIN_BYPASS, gainStageOn);
			chk("ref", rTab[i], activeReference);
		end
		channelSelectField <= 5'h02;
		repeat (2) @(posedge clk);
		pulse(GO);
		repeat (12) @(posedge clk);
		channelSelectField <= 5'h04;
		repeat (4) @(posedge clk);
		chk("chanHeld", 10'h002, activeChannel);
		waitDone;
		repeat (2) @(posedge clk);
		chk("chanNew", 10'h004, activeChannel);
		pulse(CLR);
		autoTriggerEnable <= 1'b1;
		triggerSelectField <= 3'h1;
		triggerSources <= 8'h02;
		repeat (20) @(posedge clk);
		triggerSources <= 8'h00;
		repeat (4) @(posedge clk);
		triggerSources <= 8'h02;
		waitDone;
		chk("trigTime", 10'h1, n >= 24 && n <= 44);
		pulse(CLR);
		repeat (80) @(posedge clk);
		chk("retrig", 10'h0, conversionCompleteFlag);
		triggerSources <= 8'h00;
		pulse(GO);
		repeat (10) @(posedge clk);
		chk("busyAuto", 10'h1, startConversionBit);
		waitDone;
		pulse(CLR);
		triggerSelectField <= TRIG_SELF;
		pulse(GO);
		waitDone;
		inputLevel <= 10'h0f0;
		repeat (4) @(posedge clk);
		chk("freeRun", 10'h1, startConversionBit);
		repeat (70) @(posedge clk);
		chk("freeLow", 10'h0f0, resultLowByte);
		autoTriggerEnable <= 1'b0;
		converterEnable <= 1'b0;
		repeat (2) @(posedge clk);
		stop_test;
	end
endmodule : test_sar_adc_conversion_control
